// ### include/udpll_pkg.sv
// constants and helpers for the usb clock loop control block
package udpll_pkg;
    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    localparam logic [15:0] udpll_ctrl_addr = 16'h1e00;
    localparam logic [15:0] udpll_ctrl_reset = 16'h2004;
    localparam logic [15:0] udpll_wr_mask = 16'h7ffc;
    localparam logic [15:0] udpll_zero16 = 16'h0000;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int unsigned udpll_restart_after_idle_bit = 14;
    localparam int unsigned udpll_restart_on_break_bit = 13;
    localparam int unsigned udpll_mult_hi = 11;
    localparam int unsigned udpll_mult_lo = 7;
    localparam int unsigned udpll_ldiv_hi = 6;
    localparam int unsigned udpll_ldiv_lo = 5;
    localparam int unsigned udpll_lock_enable_bit = 4;
    localparam int unsigned udpll_bdiv_hi = 3;
    localparam int unsigned udpll_bdiv_lo = 2;
    localparam int unsigned udpll_break_bit = 1;
    localparam int unsigned udpll_lock_bit = 0;
    // ---------------------------------------------------------------
    // divider codes
    // ---------------------------------------------------------------
    localparam logic [1:0] udpll_bdiv_half = 2'h2;
    localparam logic [1:0] udpll_bdiv_quarter = 2'h3;
    localparam logic [2:0] udpll_ratio_one = 3'h1;
    localparam logic [2:0] udpll_ratio_two = 3'h2;
    localparam logic [2:0] udpll_ratio_four = 3'h4;

    typedef enum logic [1:0] {
        udpll_bypass,
        udpll_acquire,
        udpll_locked,
        udpll_idle
    } udpll_state_e;

    // bypass divide ratio: 00/01 by 1, 10 by 2, 11 by 4
    function automatic logic [2:0] udpll_bypass_ratio(input logic [1:0] code);
        case (code)
            udpll_bdiv_half: udpll_bypass_ratio = udpll_ratio_two;
            udpll_bdiv_quarter: udpll_bypass_ratio = udpll_ratio_four;
            default: udpll_bypass_ratio = udpll_ratio_one;
        endcase
    endfunction

    // lock divide ratio: code plus one
    function automatic logic [2:0] udpll_lock_ratio(input logic [1:0] code);
        udpll_lock_ratio = {1'b0, code} + 3'h1;
    endfunction
endpackage

// ### include/udpll_div_if.sv
// link between the control logic and the bypass divider
`timescale 1ns/1ps
interface udpll_div_if;
    logic run;
    logic [2:0] ratio;
    logic tick;
    modport ctrl (output run, output ratio, input tick);
    modport div (input run, input ratio, output tick);
endinterface

// ### src/udpll_bypass_div.sv
// bypass-mode divider producing one output clock enable per period
`timescale 1ns/1ps
module udpll_bypass_div
    import udpll_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // control side
    udpll_div_if.div dv
);
    logic [2:0] count;
    logic [2:0] next_count;
    logic tick;
    logic next_tick;

    // ---------------------------------------------------------------
    // divide counter
    // ---------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!dv.run) begin
            next_count = 3'h0;
        end else if (count + 3'h1 >= dv.ratio) begin
            next_count = 3'h0;
            next_tick = 1'b1;
        end else begin
            next_count = count + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= 3'h0;
            tick <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign dv.tick = tick;
endmodule

// ### src/udpll_ctrl.sv
// usb clock loop control register, mode sequencing and indicators
`timescale 1ns/1ps
module udpll_ctrl
    import udpll_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // io register port
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    // analog loop side
    input wire logic lock_detect,
    input wire logic idle_req,
    output logic loop_run,
    output logic [4:0] loop_mult,
    output logic [2:0] loop_div,
    // output clock select
    output logic lock_mode,
    output logic bypass_tick
);
    udpll_div_if dv ();

    logic lock_meta;
    logic lock_sync;
    logic lock_prev;
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic brk;
    logic next_brk;
    udpll_state_e state;
    udpll_state_e next_state;
    udpll_state_e saved;
    udpll_state_e next_saved;
    logic [15:0] next_rdata;
    logic next_loop_run;
    logic [4:0] next_loop_mult;
    logic [2:0] next_loop_div;
    logic next_lock_mode;
    logic next_bypass_tick;
    logic wr_hit;
    logic lock_fall;
    logic lock_rise;
    logic en_now;
    logic en_was;
    logic rd_hit;
    logic tick_allowed;

    // ---------------------------------------------------------------
    // lock detect synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            lock_prev <= 1'b0;
        end else if (ce) begin
            lock_meta <= lock_detect;
            lock_sync <= lock_meta;
            lock_prev <= lock_sync;
        end
    end

    // lock edges are taken after the synchroniser only
    assign lock_fall = lock_prev && !lock_sync;
    assign lock_rise = !lock_prev && lock_sync;
    assign wr_hit = io_wr && (io_addr == udpll_ctrl_addr);
    assign rd_hit = io_rd && (io_addr == udpll_ctrl_addr);
    assign en_was = ctrl[udpll_lock_enable_bit];
    assign en_now = next_ctrl[udpll_lock_enable_bit];

    // ---------------------------------------------------------------
    // register, break flag and mode sequencing
    // ---------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_brk = brk;
        next_state = state;
        next_saved = saved;
        if (wr_hit) begin
            // bit 12 is stored as written; software keeps it zero
            next_ctrl = io_wdata & udpll_wr_mask;
        end
        if (state == udpll_locked && lock_fall) begin
            next_brk = 1'b0;
        end else if (lock_rise) begin
            next_brk = 1'b1;
        end
        // a write forces the break flag back to one
        if (wr_hit) begin
            next_brk = 1'b1;
        end
        case (state)
            udpll_bypass: begin
                if (idle_req) begin
                    next_saved = state;
                    next_state = udpll_idle;
                end else if (en_now && (!en_was || wr_hit)) begin
                    next_state = udpll_acquire;
                end
            end
            udpll_acquire: begin
                if (idle_req) begin
                    next_saved = state;
                    next_state = udpll_idle;
                end else if (!en_now) begin
                    next_state = udpll_bypass;
                end else if (lock_sync) begin
                    next_state = udpll_locked;
                end
            end
            udpll_locked: begin
                if (idle_req) begin
                    next_saved = state;
                    next_state = udpll_idle;
                end else if (!en_now) begin
                    next_state = udpll_bypass;
                end else if (wr_hit) begin
                    next_state = udpll_acquire;
                end else if (lock_fall && ctrl[udpll_restart_on_break_bit]) begin
                    next_state = udpll_acquire;
                end
                // break with restart_on_break clear keeps the lock state
            end
            udpll_idle: begin
                if (!idle_req) begin
                    if (ctrl[udpll_restart_after_idle_bit]) begin
                        next_state = en_now ? udpll_acquire : udpll_bypass;
                    end else if (saved == udpll_locked) begin
                        // loop was stopped in idle: lock again with the kept settings
                        next_state = udpll_acquire;
                    end else begin
                        next_state = saved;
                    end
                end
            end
            default: next_state = udpll_bypass;
        endcase
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_comb begin
        next_rdata = udpll_zero16;
        if (rd_hit) begin
            next_rdata = ctrl & udpll_wr_mask;
            next_rdata[udpll_break_bit] = brk;
            next_rdata[udpll_lock_bit] = (state == udpll_locked);
        end
        next_loop_run = (next_state == udpll_acquire) || (next_state == udpll_locked);
        next_loop_mult = next_ctrl[udpll_mult_hi:udpll_mult_lo];
        next_loop_div = udpll_lock_ratio(next_ctrl[udpll_ldiv_hi:udpll_ldiv_lo]);
        next_lock_mode = (next_state == udpll_locked);
        // no bypass pulse once the locked clock or idle is selected
        tick_allowed = (next_state == udpll_bypass) || (next_state == udpll_acquire);
        next_bypass_tick = dv.tick && tick_allowed;
    end

    // bypass divider runs only in bypass and acquire, and is stopped while locked or idle
    assign dv.run = (state != udpll_locked) && (state != udpll_idle);
    assign dv.ratio = udpll_bypass_ratio(ctrl[udpll_bdiv_hi:udpll_bdiv_lo]);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= udpll_ctrl_reset;
            brk <= 1'b1;
            state <= udpll_bypass;
            saved <= udpll_bypass;
            io_rdata <= udpll_zero16;
            loop_run <= 1'b0;
            loop_mult <= 5'h00;
            loop_div <= udpll_ratio_one;
            lock_mode <= 1'b0;
            bypass_tick <= 1'b0;
        end else if (ce) begin
            ctrl <= next_ctrl;
            brk <= next_brk;
            state <= next_state;
            saved <= next_saved;
            io_rdata <= next_rdata;
            loop_run <= next_loop_run;
            loop_mult <= next_loop_mult;
            loop_div <= next_loop_div;
            lock_mode <= next_lock_mode;
            bypass_tick <= next_bypass_tick;
        end
    end

    udpll_bypass_div u_div (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ce(ce),
        .dv(dv)
    );
endmodule

// ### verification/udpll_ctrl_props.sv
// assertion checker for the usb clock loop control block
`timescale 1ns/1ps
module udpll_ctrl_props
    import udpll_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // io register port
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_wdata,
    input wire logic [15:0] io_rdata,
    // analog loop side
    input wire logic lock_detect,
    input wire logic idle_req,
    input wire logic loop_run,
    input wire logic [4:0] loop_mult,
    input wire logic [2:0] loop_div,
    // output clock select
    input wire logic lock_mode,
    input wire logic bypass_tick
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_wr;
        ce && io_wr && io_addr == udpll_ctrl_addr && !idle_req;
    endsequence
    sequence s_rd;
        ce && io_rd && io_addr == udpll_ctrl_addr;
    endsequence
    a_write_starts_loop: assert property (s_wr ##0 io_wdata[4] |=> loop_run
        && loop_mult == $past(io_wdata[11:7]) && loop_div == {1'b0, $past(io_wdata[6:5])} + 3'h1)
        else $error("loop settings not taken from write");
    a_write_bypass: assert property (s_wr ##0 !io_wdata[4] |=> !loop_run ##1 !lock_mode)
        else $error("loop still running after disable");
    a_lock_needs_run: assert property (lock_mode |-> $past(loop_run))
        else $error("lock shown without running loop");
    a_no_tick_locked: assert property (lock_mode && $past(lock_mode) |-> !bypass_tick)
        else $error("bypass tick while locked");
    a_lock_after_detect: assert property ($rose(lock_mode) |-> $past(lock_detect, 3))
        else $error("lock without lock detect");
    a_idle_stops: assert property (ce && idle_req |=> !loop_run && !bypass_tick && !lock_mode)
        else $error("loop active in idle");
    a_unmapped_zero: assert property (ce && !(io_rd && io_addr == udpll_ctrl_addr)
        |=> io_rdata == udpll_zero16) else $error("read data not zero");
    a_write_sets_break: assert property (s_wr ##1 s_rd |=> io_rdata[1] && !io_rdata[15])
        else $error("break bit not set by write");
    a_lock_bit_read: assert property (s_rd |=> io_rdata[0] == $past(lock_mode))
        else $error("lock bit differs from lock mode");
endmodule
bind udpll_ctrl udpll_ctrl_props i_props (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .lock_detect(lock_detect), .idle_req(idle_req), .loop_run(loop_run), .loop_mult(loop_mult),
    .loop_div(loop_div), .lock_mode(lock_mode), .bypass_tick(bypass_tick));

// ### verification/udpll_ctrl_test.sv
// self-checking bench for the usb clock loop control block
`timescale 1ns/1ps
module udpll_ctrl_test import udpll_pkg::*; ;
    logic ref_clk = 0, resetn = 0, ce = 1, io_wr = 0, io_rd = 0, lock_detect = 0, idle_req = 0;
    logic [15:0] io_addr = 16'h1e00, io_wdata = 16'h0000, io_rdata, w;
    logic loop_run, lock_mode, bypass_tick;
    logic [4:0] loop_mult;
    logic [2:0] loop_div;
    int errors = 0, check_count = 0, cycles = 0;
    // input clock of the loop assumed for the usb clock setting
    localparam int in_clk_mhz = 12;
    udpll_ctrl i_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .lock_detect(lock_detect), .idle_req(idle_req), .loop_run(loop_run),
        .loop_mult(loop_mult), .loop_div(loop_div), .lock_mode(lock_mode),
        .bypass_tick(bypass_tick));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge ref_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge ref_clk);
        io_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] exp, string name);
        @(posedge ref_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge ref_clk);
        io_rd <= 1'b0;
        #1;
        check(name, exp, io_rdata);
    endtask
    task automatic ticks(int n, int exp);
        int cnt = 0;
        repeat (n) begin
            step(1);
            cnt += int'(bypass_tick);
        end
        check("tick count", 16'(exp), 16'(cnt));
    endtask
    task automatic wait_lock();
        for (int i = 0; i < 12 && lock_mode !== 1'b1; i++) step(1);
        check("lock_mode", 16'h0001, 16'(lock_mode));
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic s_reset();
        rd(udpll_ctrl_addr, 16'h2006, "reset word");
        ticks(8, 8);
    endtask
    task automatic s_bypass();
        int rat[4] = '{1, 1, 2, 4};
        for (int c = 0; c < 4; c++) begin
            wr(udpll_ctrl_addr, 16'(c << 2));
            ticks(16, 16 / rat[c]);
        end
        @(posedge ref_clk) ce <= 1'b0;
        // the ratio-4 pulse standing at the freeze is held while ce is low
        ticks(8, 8);
        @(posedge ref_clk) ce <= 1'b1;
    endtask
    task automatic s_regmap();
        wr(16'h1e01, 16'hffff);
        rd(udpll_ctrl_addr, 16'h000e, "after unmapped write");
        rd(16'h1e02, 16'h0000, "unmapped read");
        wr(udpll_ctrl_addr, 16'h8003);
        rd(udpll_ctrl_addr, 16'h0002, "masked word");
        // write then read on the very next edge
        @(posedge ref_clk);
        io_wdata <= 16'h000c;
        io_wr <= 1'b1;
        @(posedge ref_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b1;
        @(posedge ref_clk);
        io_rd <= 1'b0;
        #1;
        check("back to back", 16'h000e, io_rdata);
    endtask
    task automatic s_lock();
        int m[4] = '{2, 31, 5, 16};
        for (int d = 0; d < 4; d++) begin
            @(posedge ref_clk) lock_detect <= 1'b0;
            w = 16'h2010 | 16'(m[d] << 7) | 16'(d << 5);
            wr(udpll_ctrl_addr, w);
            check("loop_mult", 16'(m[d]), 16'(loop_mult));
            check("loop_div", 16'(d + 1), 16'(loop_div));
            step(4);
            check("early lock", 16'h0000, 16'(lock_mode));
            @(posedge ref_clk) lock_detect <= 1'b1;
            wait_lock();
            rd(udpll_ctrl_addr, w | 16'h0003, "locked word");
        end
        // last setting gives the usb module clock from the assumed input clock
        check("usb clock", 16'h0030, 16'(in_clk_mhz * int'(loop_mult) / int'(loop_div)));
    endtask
    task automatic s_break();
        @(posedge ref_clk) lock_detect <= 1'b0;
        step(6);
        check("restart run", 16'h0001, 16'(loop_run));
        rd(udpll_ctrl_addr, w, "broken word");
        @(posedge ref_clk) lock_detect <= 1'b1;
        wait_lock();
        rd(udpll_ctrl_addr, w | 16'h0003, "relocked word");
        w = w & 16'hdfff;
        wr(udpll_ctrl_addr, w);
        wait_lock();
        @(posedge ref_clk) lock_detect <= 1'b0;
        step(6);
        rd(udpll_ctrl_addr, w | 16'h0001, "kept lock word");
        wr(udpll_ctrl_addr, w);
        rd(udpll_ctrl_addr, w | 16'h0002, "written word");
        @(posedge ref_clk) lock_detect <= 1'b1;
        wait_lock();
    endtask
    task automatic s_idle();
        @(posedge ref_clk) idle_req <= 1'b1;
        step(2);
        check("idle run", 16'h0000, 16'(loop_run));
        @(posedge ref_clk) idle_req <= 1'b0;
        step(3);
        check("resumed lock", 16'h0001, 16'(lock_mode));
        wr(udpll_ctrl_addr, w | 16'h4000);
        wait_lock();
        @(posedge ref_clk) idle_req <= 1'b1;
        lock_detect <= 1'b0;
        step(2);
        @(posedge ref_clk) idle_req <= 1'b0;
        step(3);
        check("restart lock", 16'h0000, 16'(lock_mode));
        check("restart run", 16'h0001, 16'(loop_run));
    endtask
    // ---------------------------------------------------------------
    // clock, timeout and main sequence
    // ---------------------------------------------------------------
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        s_reset();
        s_bypass();
        s_regmap();
        s_lock();
        s_break();
        s_idle();
        end_sim();
    end
endmodule
